/* File: logic/usart_ports.sv */
`timescale 1ns/100ps
module usart_ports (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic       cnd_i,
  input  wire logic [7:0] din_i,
  input  wire logic       ext_sync_i,
  input  wire logic       cs_n_i,
  input  wire logic       cts_n_i,
  input  wire logic       dsr_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       rxc_n_i,
  input  wire logic       txc_n_i,
  input  wire logic       rxd_i,
  output logic      [7:0] dout_o,
  output logic            oe_n_o,
  output logic            dtr_n_o,
  output logic            rts_n_o,
  output logic            rx_ready_o,
  output logic            sync_break_o,
  output logic            txd_o,
  output logic            tx_empty_o,
  output logic            tx_ready_o
);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HUNT} rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic       rst_n;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q <= 2'h0; // RULE10
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] din_s1_q, din_q;
  logic [1:0] cs_n_s_q, rd_n_s_q, wr_n_s_q, cnd_s_q;
  logic [1:0] cts_s_q, dsr_s_q, rxd_s_q, sync_s_q;
  logic       rd_act, wr_act, rd_prev_q, wr_prev_q;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      din_s1_q <= 8'h00;
      din_q    <= 8'h00;
      cs_n_s_q <= 2'h3;
      rd_n_s_q <= 2'h3;
      wr_n_s_q <= 2'h3;
      cnd_s_q  <= 2'h0;
      cts_s_q  <= 2'h3;
      dsr_s_q  <= 2'h3;
      rxd_s_q  <= 2'h3;
      sync_s_q <= 2'h0;
    end else begin
      din_s1_q <= din_i;
      din_q    <= din_s1_q;
      cs_n_s_q <= {cs_n_s_q[0], cs_n_i};
      rd_n_s_q <= {rd_n_s_q[0], rd_n_i};
      wr_n_s_q <= {wr_n_s_q[0], wr_n_i};
      cnd_s_q  <= {cnd_s_q[0], cnd_i};
      cts_s_q  <= {cts_s_q[0], cts_n_i};
      dsr_s_q  <= {dsr_s_q[0], dsr_n_i};
      rxd_s_q  <= {rxd_s_q[0], rxd_i};
      sync_s_q <= {sync_s_q[0], ext_sync_i};
    end
  end

  assign rd_act = ~cs_n_s_q[1] & ~rd_n_s_q[1]; // RULE2 RULE4
  assign wr_act = ~cs_n_s_q[1] & ~wr_n_s_q[1]; // RULE3 RULE4

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
    end
  end

  // ----------------------------------------------------------------
  // link clock edges
  // ----------------------------------------------------------------
  link_edges_if edges ();

  link_edges u_edges (
    .mclk_i  (mclk_i),
    .rstn_i  (rst_n),
    .rxc_n_i (rxc_n_i),
    .txc_n_i (txc_n_i),
    .edges   (edges.source)
  );

  // ----------------------------------------------------------------
  // mode and command
  // ----------------------------------------------------------------
  logic       wr_start, wr_ctrl, wr_data, rd_data_end;
  logic       expect_mode_q;
  logic [7:0] mode_q, cmd_q;
  logic       sync_mode, tx_en;

  // one write per strobe, taken at its leading edge
  assign wr_start    = wr_act & ~wr_prev_q;
  assign wr_ctrl     = wr_start & cnd_s_q[1];  // RULE1
  assign wr_data     = wr_start & ~cnd_s_q[1]; // RULE1
  assign rd_data_end = ~rd_act & rd_prev_q & ~cnd_s_q[1];
  assign sync_mode   = (mode_q[1:0] == usart_pkg::BAUD_SYNC);
  assign tx_en       = ~cts_s_q[1] & cmd_q[usart_pkg::CMD_TXEN]; // RULE6

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      expect_mode_q <= 1'b1;
      mode_q        <= usart_pkg::MODE_RST;
      cmd_q         <= usart_pkg::CMD_RST;
    end else if (wr_ctrl) begin
      if (expect_mode_q) begin
        mode_q        <= din_q;
        expect_mode_q <= 1'b0;
      end else if (din_q[usart_pkg::CMD_IRST]) begin
        cmd_q         <= usart_pkg::CMD_RST;
        expect_mode_q <= 1'b1;
      end else begin
        cmd_q <= din_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  rx_state_t  rx_st_q;
  logic [7:0] rx_cnt_q, rx_sh_q, rx_buf_q;
  logic [3:0] rx_bits_q;
  logic       rx_par_q, rx_done, rx_ready_q;
  logic       perr_q, oerr_q, ferr_q, brk_q, syn_q;
  logic       rx_tick, rx_mid, rx_en, err_clr;
  logic [7:0] rx_word;

  assign rx_en   = cmd_q[usart_pkg::CMD_RXEN] & ~expect_mode_q;
  assign rx_tick = edges.rx_rise;
  assign rx_mid  = (rx_cnt_q + 8'h01) == ((usart_pkg::bit_ticks(mode_q) >> 1) + 8'h01);
  assign rx_word = rx_sh_q >> (4'h8 - usart_pkg::word_bits(mode_q));
  assign err_clr = wr_ctrl & ~expect_mode_q & din_q[usart_pkg::CMD_ERST];

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q   <= RX_IDLE;
      rx_cnt_q  <= 8'h00;
      rx_bits_q <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_par_q  <= 1'b0;
    end else if (!rx_en) begin
      rx_st_q <= RX_IDLE;
    end else if (rx_tick) begin // RULE9
      case (rx_st_q)
        RX_IDLE: begin
          rx_bits_q <= 4'h0;
          if (sync_mode) begin
            rx_st_q <= RX_HUNT;
          end else if (!rxd_s_q[1]) begin
            rx_cnt_q <= 8'h00;
            rx_st_q  <= rx_mid ? RX_DATA : RX_START;
          end
        end
        RX_HUNT: begin
          if (sync_s_q[1]) begin
            rx_sh_q   <= {rxd_s_q[1], rx_sh_q[7:1]};
            rx_bits_q <= 4'h1;
            rx_st_q   <= RX_DATA; // RULE5
          end
        end
        RX_START: begin
          rx_cnt_q <= rx_cnt_q + 8'h01;
          if (rx_mid) begin
            rx_cnt_q <= 8'h00;
            rx_st_q  <= rxd_s_q[1] ? RX_IDLE : RX_DATA;
          end
        end
        default: begin
          rx_cnt_q <= rx_cnt_q + 8'h01;
          if (sync_mode || rx_cnt_q + 8'h01 == usart_pkg::bit_ticks(mode_q)) begin
            rx_cnt_q <= 8'h00;
            if (rx_st_q == RX_DATA) begin
              rx_sh_q   <= {rxd_s_q[1], rx_sh_q[7:1]};
              rx_bits_q <= rx_bits_q + 4'h1;
              if (rx_bits_q + 4'h1 == usart_pkg::word_bits(mode_q)) begin
                rx_bits_q <= 4'h0;
                if (mode_q[usart_pkg::MODE_PEN]) begin
                  rx_st_q <= RX_PAR;
                end else begin
                  rx_st_q <= sync_mode ? RX_DATA : RX_STOP;
                end
              end
            end else if (rx_st_q == RX_PAR) begin
              rx_par_q <= rxd_s_q[1];
              rx_st_q  <= sync_mode ? RX_DATA : RX_STOP;
            end else begin
              rx_st_q <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // a character completes at its stop bit, or at its last bit in sync mode
  always_comb begin
    rx_done = 1'b0;
    if (rx_en && rx_tick && (sync_mode || rx_cnt_q + 8'h01 == usart_pkg::bit_ticks(mode_q))) begin
      if (rx_st_q == RX_STOP) begin
        rx_done = 1'b1;
      end else if (sync_mode && rx_st_q == RX_PAR) begin
        rx_done = 1'b1;
      end else if (sync_mode && rx_st_q == RX_DATA && !mode_q[usart_pkg::MODE_PEN]
                   && rx_bits_q + 4'h1 == usart_pkg::word_bits(mode_q)) begin
        rx_done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_buf_q   <= 8'h00;
      rx_ready_q <= 1'b0;
    end else if (rx_done) begin
      // last data bit not yet shifted in sync mode without parity: align on live bit
      rx_buf_q   <= (sync_mode && rx_st_q == RX_DATA)
                    ? ({rxd_s_q[1], rx_sh_q[7:1]} >> (4'h8 - usart_pkg::word_bits(mode_q)))
                    : rx_word;
      rx_ready_q <= 1'b1; // RULE14
    end else if (rd_data_end) begin
      rx_ready_q <= 1'b0; // RULE19
    end
  end

  // errors: a new event wins over the error-reset command
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      perr_q <= 1'b0;
      oerr_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      if (rx_done && rx_st_q != RX_DATA && mode_q[usart_pkg::MODE_PEN]) begin
        perr_q <= (rx_st_q == RX_PAR ? rxd_s_q[1] : rx_par_q)
                  != usart_pkg::par_bit(rx_word, mode_q);
      end else if (err_clr) begin
        perr_q <= 1'b0;
      end
      if (rx_done && rx_ready_q) begin
        oerr_q <= 1'b1;
      end else if (err_clr) begin
        oerr_q <= 1'b0;
      end
      if (rx_done && !sync_mode && !rxd_s_q[1]) begin
        ferr_q <= 1'b1;
      end else if (err_clr) begin
        ferr_q <= 1'b0;
      end
    end
  end

  // break holds until the line returns to mark
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      brk_q <= 1'b0;
      syn_q <= 1'b0;
    end else begin
      if (rx_done && !sync_mode && !rxd_s_q[1] && rx_word == 8'h00) begin
        brk_q <= 1'b1; // RULE15
      end else if (rxd_s_q[1] || sync_mode) begin
        brk_q <= 1'b0;
      end
      if (rx_tick && rx_st_q == RX_HUNT && sync_s_q[1]) begin
        syn_q <= 1'b1;
      end else if (!sync_mode || (rd_data_end == 1'b0 && rd_act && cnd_s_q[1])) begin
        syn_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  tx_state_t  tx_st_q;
  logic [7:0] tx_hold_q, tx_sh_q, tx_cnt_q;
  logic [3:0] tx_bits_q;
  logic       hold_full_q, tx_load, tx_line_q, tx_par_q;

  assign tx_load = edges.tx_fall && tx_st_q == TX_IDLE && hold_full_q && tx_en; // RULE6

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold_q   <= 8'h00;
      hold_full_q <= 1'b0;
    end else if (wr_data) begin
      tx_hold_q   <= din_q; // RULE3
      hold_full_q <= 1'b1;
    end else if (tx_load || expect_mode_q) begin
      hold_full_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q   <= TX_IDLE;
      tx_sh_q   <= 8'h00;
      tx_cnt_q  <= 8'h00;
      tx_bits_q <= 4'h0;
      tx_par_q  <= 1'b0;
      tx_line_q <= 1'b1;
    end else if (expect_mode_q) begin
      tx_st_q   <= TX_IDLE;
      tx_line_q <= 1'b1;
    end else if (edges.tx_fall) begin // RULE8
      if (tx_st_q == TX_IDLE) begin
        tx_line_q <= 1'b1;
        if (tx_load) begin
          tx_par_q  <= usart_pkg::par_bit(tx_hold_q, mode_q);
          tx_cnt_q  <= usart_pkg::bit_ticks(mode_q) - 8'h01;
          tx_bits_q <= 4'h0;
          if (sync_mode) begin
            tx_line_q <= tx_hold_q[0];
            tx_sh_q   <= tx_hold_q >> 1;
            tx_bits_q <= 4'h1;
            tx_st_q   <= TX_DATA;
          end else begin
            tx_line_q <= 1'b0;
            tx_sh_q   <= tx_hold_q;
            tx_st_q   <= TX_START;
          end
        end
      end else if (tx_cnt_q != 8'h00) begin
        tx_cnt_q <= tx_cnt_q - 8'h01;
      end else begin
        tx_cnt_q <= usart_pkg::bit_ticks(mode_q) - 8'h01;
        case (tx_st_q)
          TX_START, TX_DATA: begin
            if (tx_st_q == TX_DATA && tx_bits_q == usart_pkg::word_bits(mode_q)) begin
              if (mode_q[usart_pkg::MODE_PEN]) begin
                tx_line_q <= tx_par_q;
                tx_st_q   <= TX_PAR;
              end else if (sync_mode) begin
                tx_line_q <= 1'b1;
                tx_st_q   <= TX_IDLE;
              end else begin
                tx_line_q <= 1'b1;
                tx_cnt_q  <= usart_pkg::stop_ticks(mode_q) - 8'h01;
                tx_st_q   <= TX_STOP;
              end
            end else begin
              tx_line_q <= tx_sh_q[0];
              tx_sh_q   <= tx_sh_q >> 1;
              tx_bits_q <= tx_bits_q + 4'h1;
              tx_st_q   <= TX_DATA;
            end
          end
          TX_PAR: begin
            tx_line_q <= 1'b1;
            if (sync_mode) begin
              tx_st_q <= TX_IDLE;
            end else begin
              tx_cnt_q <= usart_pkg::stop_ticks(mode_q) - 8'h01;
              tx_st_q  <= TX_STOP;
            end
          end
          default: begin
            tx_line_q <= 1'b1;
            tx_st_q   <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // host read path and registered outputs
  // ----------------------------------------------------------------
  logic [7:0] status;

  always_comb begin
    status                      = 8'h00;
    status[usart_pkg::ST_TXRDY] = ~hold_full_q;
    status[usart_pkg::ST_RXRDY] = rx_ready_q;
    status[usart_pkg::ST_TXEMP] = ~hold_full_q & (tx_st_q == TX_IDLE);
    status[usart_pkg::ST_PERR]  = perr_q;
    status[usart_pkg::ST_OERR]  = oerr_q;
    status[usart_pkg::ST_FERR]  = ferr_q;
    status[usart_pkg::ST_SYNBK] = sync_mode ? syn_q : brk_q;
    status[usart_pkg::ST_DSR]   = ~dsr_s_q[1]; // RULE7
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dout_o <= 8'h00;
      oe_n_o <= 1'b1;
    end else begin
      oe_n_o <= ~rd_act; // RULE13
      if (rd_act) begin
        dout_o <= cnd_s_q[1] ? status : rx_buf_q; // RULE1 RULE2
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dtr_n_o      <= 1'b1;
      rts_n_o      <= 1'b1;
      rx_ready_o   <= 1'b0;
      sync_break_o <= 1'b0;
      txd_o        <= 1'b1;
      tx_empty_o   <= 1'b1;
      tx_ready_o   <= 1'b0;
    end else begin
      dtr_n_o      <= ~cmd_q[usart_pkg::CMD_DTR]; // RULE11
      rts_n_o      <= ~cmd_q[usart_pkg::CMD_RTS]; // RULE12
      rx_ready_o   <= rx_ready_q; // RULE14
      sync_break_o <= status[usart_pkg::ST_SYNBK]; // RULE15
      txd_o        <= tx_line_q & ~cmd_q[usart_pkg::CMD_SBRK]; // RULE8
      tx_empty_o   <= status[usart_pkg::ST_TXEMP]; // RULE16
      tx_ready_o   <= ~hold_full_q & ~expect_mode_q & tx_en; // RULE17 RULE18
    end
  end

endmodule : usart_ports

/* File: pkg/usart_pkg.sv */
// Notes on behaviour
// RULE1 - control/data select high means status or control, low means character data
// RULE2 - host read happens only while read strobe and chip select are both low
// RULE3 - host write happens only while write strobe and chip select are low
// RULE4 - every host access is ignored while chip select is high
// RULE5 - sync mode: external sync detect starts reception at next receive clock rise
// RULE6 - transmission runs only with clear-to-send low and transmit enable set; code checks both only when a character starts
// RULE7 - status bit 7 shows the data-set-ready level
// RULE8 - serial output changes only on transmit clock falling edges; code also pulls it low as soon as send break (command bit 3) is set
// RULE9 - receiver samples on receive clock rises scaled by baud factor
// RULE10 - reset input clears all registers and control at once, without clock
// RULE11 - data-terminal-ready output low while command bit 1 is set
// RULE12 - request-to-send output low while command bit 5 is set
// RULE13 - output enable low whenever read data is driven on output bus
// RULE14 - receiver ready high while a received character waits
// RULE15 - async mode: sync/break output high while a break is on receive line
// RULE16 - transmitter empty high when nothing is left to send
// RULE17 - transmitter ready high when another byte can be accepted
// RULE18 - transmitter ready only with clear-to-send active and transmit enable set
// RULE19 - data read clears receiver ready until next character arrives
package usart_pkg;

  // ----------------------------------------------------------------
  // command bits
  // ----------------------------------------------------------------
  localparam int CMD_TXEN = 0;
  localparam int CMD_DTR  = 1;
  localparam int CMD_RXEN = 2;
  localparam int CMD_SBRK = 3;
  localparam int CMD_ERST = 4;
  localparam int CMD_RTS  = 5;
  localparam int CMD_IRST = 6;

  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  localparam int ST_TXRDY = 0;
  localparam int ST_RXRDY = 1;
  localparam int ST_TXEMP = 2;
  localparam int ST_PERR  = 3;
  localparam int ST_OERR  = 4;
  localparam int ST_FERR  = 5;
  localparam int ST_SYNBK = 6;
  localparam int ST_DSR   = 7;

  // ----------------------------------------------------------------
  // mode fields and reset values
  // ----------------------------------------------------------------
  localparam int MODE_PEN = 4;
  localparam int MODE_EP  = 5;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CMD_RST  = 8'h00;
  localparam logic [1:0] BAUD_SYNC = 2'h0;
  localparam logic [1:0] BAUD_X16  = 2'h2;
  localparam logic [1:0] BAUD_X64  = 2'h3;
  localparam logic [1:0] STOP_1P5  = 2'h2;
  localparam logic [1:0] STOP_2    = 2'h3;

  // ----------------------------------------------------------------
  // timing counts in link clock edges per bit
  // ----------------------------------------------------------------
  localparam logic [7:0] TICKS_X1  = 8'h01;
  localparam logic [7:0] TICKS_X16 = 8'h10;
  localparam logic [7:0] TICKS_X64 = 8'h40;

  function automatic logic [7:0] bit_ticks(input logic [7:0] mode);
    case (mode[1:0])
      BAUD_X16: bit_ticks = TICKS_X16;
      BAUD_X64: bit_ticks = TICKS_X64;
      default:  bit_ticks = TICKS_X1;
    endcase
  endfunction : bit_ticks

  // 1.5 stop bits at x1 collapses to one bit period
  function automatic logic [7:0] stop_ticks(input logic [7:0] mode);
    case (mode[7:6])
      STOP_1P5: stop_ticks = bit_ticks(mode) + (bit_ticks(mode) >> 1);
      STOP_2:   stop_ticks = bit_ticks(mode) << 1;
      default:  stop_ticks = bit_ticks(mode);
    endcase
  endfunction : stop_ticks

  function automatic logic [3:0] word_bits(input logic [7:0] mode);
    word_bits = 4'h5 + {2'h0, mode[3:2]};
  endfunction : word_bits

  function automatic logic par_bit(input logic [7:0] data, input logic [7:0] mode);
    logic [7:0] mask;
    mask    = 8'hFF >> (4'h8 - word_bits(mode));
    par_bit = (^(data & mask)) ^ ~mode[MODE_EP];
  endfunction : par_bit

endpackage : usart_pkg

/* File: pkg/link_edges_if.sv */
`timescale 1ns/100ps
interface link_edges_if;
  logic rx_rise;
  logic tx_fall;
  modport source (output rx_rise, output tx_fall);
  modport sink   (input  rx_rise, input  tx_fall);
endinterface : link_edges_if

/* File: logic/link_edges.sv */
`timescale 1ns/100ps
module link_edges (
  input  wire logic   mclk_i,
  input  wire logic   rstn_i,
  input  wire logic   rxc_n_i,
  input  wire logic   txc_n_i,
  link_edges_if.source edges
);

  // ----------------------------------------------------------------
  // two-stage sync, third stage only for edge finding
  // ----------------------------------------------------------------
  logic [2:0] rxc_q;
  logic [2:0] txc_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rxc_q <= 3'h7;
      txc_q <= 3'h7;
    end else begin
      rxc_q <= {rxc_q[1:0], rxc_n_i};
      txc_q <= {txc_q[1:0], txc_n_i};
    end
  end

  assign edges.rx_rise = rxc_q[1] & ~rxc_q[2]; // RULE9
  assign edges.tx_fall = ~txc_q[1] & txc_q[2]; // RULE8

endmodule : link_edges

/* File: bench/usart_ports_chk.sv */
`timescale 1ns/100ps
module usart_ports_chk (
  input logic mclk_i,
  input logic rstn_i,
  input logic cnd_i,
  input logic cs_n_i,
  input logic rd_n_i,
  input logic cts_n_i,
  input logic txc_n_i,
  input logic oe_n_o,
  input logic dtr_n_o,
  input logic rts_n_o,
  input logic rx_ready_o,
  input logic txd_o,
  input logic tx_empty_o,
  input logic tx_ready_o
);
  // ----------------------------------------------------------------
  // gap counters, saturating so idle stretches never wrap
  // ----------------------------------------------------------------
  logic [3:0] cs_gap_q, cts_hi_q, fall_gap_q, rd_gap_q;
  logic       txc_q;
  logic       data_rd;
  assign data_rd = !cs_n_i && !rd_n_i && !cnd_i;
  function automatic logic [3:0] sat(input logic [3:0] v);
    return v + {3'h0, v != 4'hF};
  endfunction : sat
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_gap_q   <= 4'hF;
      cts_hi_q   <= 4'hF;
      rd_gap_q   <= 4'hF;
      fall_gap_q <= 4'hF;
      txc_q      <= 1'b1;
    end else begin
      cs_gap_q   <= cs_n_i ? sat(cs_gap_q) : 4'h0;
      cts_hi_q   <= cts_n_i ? sat(cts_hi_q) : 4'h0;
      rd_gap_q   <= data_rd ? 4'h0 : sat(rd_gap_q);
      fall_gap_q <= (txc_q && !txc_n_i) ? 4'h0 : sat(fall_gap_q);
      txc_q      <= txc_n_i;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence rd_end;
    !cs_n_i && !rd_n_i ##1 (cs_n_i || rd_n_i);
  endsequence
  sequence data_end;
    data_rd ##1 !data_rd;
  endsequence
  a_oe_cause: assert property ($fell(oe_n_o) |-> $past(!cs_n_i && !rd_n_i, 3))
    else $error("output enable without selected read");
  a_oe_release: assert property (rd_end |-> ##[1:5] oe_n_o)
    else $error("output enable stuck after read");
  a_rx_clear: assert property (data_end |-> ##[1:8] !rx_ready_o)
    else $error("receiver ready kept after data read");
  a_rx_hold: assert property ($fell(rx_ready_o) |-> rd_gap_q < 4'hA)
    else $error("receiver ready dropped without read");
  a_ctl_cs: assert property ($changed(dtr_n_o) || $changed(rts_n_o) |-> cs_gap_q < 4'h8)
    else $error("modem output changed without selected write");
  a_txrdy_cts: assert property (tx_ready_o |-> cts_hi_q < 4'h6)
    else $error("transmitter ready with clear to send off");
  a_txd_edge: assert property ($changed(txd_o) |-> fall_gap_q inside {[4'h2:4'h8]})
    else $error("serial output moved away from clock fall");
  a_empty_quiet: assert property (tx_empty_o && $past(tx_empty_o) |-> $stable(txd_o))
    else $error("serial output moved while empty");
endmodule : usart_ports_chk

/* File: bench/modem_model.sv */
`timescale 1ns/100ps
module modem_model (
  input  logic run_i,
  output logic lclk_n_o,
  output logic rxd_o
);
  // link clock parks high while run_i is low; odd offset keeps it off mclk phase
  initial begin
    lclk_n_o = 1'b1;
    rxd_o    = 1'b1;
    #13.7;
    forever begin
      #40;
      lclk_n_o = run_i ? ~lclk_n_o : 1'b1;
    end
  end
  // rxd moves on falls so every rise sees a settled bit
  task automatic send(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      @(negedge lclk_n_o);
      rxd_o = f[i];
    end
  endtask : send
  task automatic brk(input int n);
    @(negedge lclk_n_o);
    rxd_o = 1'b0;
    repeat (n) @(negedge lclk_n_o);
    rxd_o = 1'b1;
  endtask : brk
endmodule : modem_model

/* File: bench/test_usart_ports.sv */
`timescale 1ns/100ps
module test_usart_ports;
  logic mclk_i, rstn_i, cnd_i, ext_sync_i, cs_n_i, cts_n_i, dsr_n_i, rd_n_i, wr_n_i;
  logic [7:0] din_i, dout_o, b, q;
  logic oe_n_o, dtr_n_o, rts_n_o, rx_ready_o, sync_break_o, txd_o, tx_empty_o, tx_ready_o;
  logic lclk, rxd, run, hold;
  logic [7:0] outs;
  assign outs = {dtr_n_o, rts_n_o, tx_empty_o, tx_ready_o, rx_ready_o, txd_o, oe_n_o,
                 sync_break_o};
  logic [9:0] f;
  logic [31:0] seed = 32'h42;
  int failures, compares;
  usart_ports uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cnd_i(cnd_i), .din_i(din_i),
    .ext_sync_i(ext_sync_i), .cs_n_i(cs_n_i), .cts_n_i(cts_n_i), .dsr_n_i(dsr_n_i),
    .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .rxc_n_i(lclk), .txc_n_i(lclk), .rxd_i(rxd),
    .dout_o(dout_o), .oe_n_o(oe_n_o), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o),
    .rx_ready_o(rx_ready_o), .sync_break_o(sync_break_o), .txd_o(txd_o),
    .tx_empty_o(tx_empty_o), .tx_ready_o(tx_ready_o));
  modem_model m (.run_i(run), .lclk_n_o(lclk), .rxd_o(rxd));
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // one host access; strobe held 5 cycles, then 6 idle
  task automatic host(input logic cs, input logic c, input logic wr, input logic [7:0] d);
    tick();
    cs_n_i = !cs;
    cnd_i  = c;
    din_i  = d;
    wr_n_i = !wr;
    rd_n_i = wr;
    repeat (5) tick();
    q = dout_o;
    chk("oe", oe_n_o, !(cs && !wr));
    {cs_n_i, rd_n_i, wr_n_i} = 3'h7;
    repeat (6) tick();
  endtask : host
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial begin
    {cs_n_i, rd_n_i, wr_n_i, cts_n_i, dsr_n_i, rstn_i} = 6'h3E;
    {cnd_i, ext_sync_i, run, din_i} = 11'h000;
    repeat (20) @(posedge mclk_i);
    #1 rstn_i = 1'b1;
    repeat (4) tick();
    chk("idle", outs, 8'hE6);
    host(1'b1, 1'b1, 1'b1, 8'h4D);
    host(1'b1, 1'b1, 1'b1, 8'h27);
    chk("modem", {dtr_n_o, rts_n_o}, 2'h0);
    host(1'b0, 1'b1, 1'b1, 8'h00);
    host(1'b0, 1'b1, 1'b0, 8'h00);
    chk("unselected", {dtr_n_o, rts_n_o}, 2'h0);
    cts_n_i = 1'b0;
    repeat (8) tick();
    chk("txrdy", tx_ready_o, 1'b1);
    cts_n_i = 1'b1;
    repeat (8) tick();
    chk("txrdy_cts", tx_ready_o, 1'b0);
    repeat (4) begin
      dsr_n_i = 1'(rnd());
      host(1'b1, 1'b1, 1'b0, 8'h00);
      chk("dsr", q[7], !dsr_n_i);
      chk("st_empty", q[usart_pkg::ST_TXEMP], 1'b1);
    end
    b = 8'(rnd());
    host(1'b1, 1'b0, 1'b1, b);
    run = 1'b1;
    hold = 1'b1;
    repeat (200) begin
      tick();
      hold &= txd_o;
    end
    chk("cts_hold", {hold, tx_empty_o}, 2'h2);
    cts_n_i = 1'b0;
    for (int n = 0; n < 400 && txd_o !== 1'b0; n++) tick();
    for (int i = 0; i < 10; i++) begin
      @(posedge lclk);
      f[i] = txd_o;
    end
    chk("frame", f, {1'b1, b, 1'b0});
    repeat (60) tick();
    chk("empty", tx_empty_o, 1'b1);
    repeat (3) begin
      b = 8'(rnd());
      m.send({1'b1, b, 1'b0});
      for (int n = 0; n < 100 && rx_ready_o !== 1'b1; n++) tick();
      chk("rxrdy", rx_ready_o, 1'b1);
      host(1'b1, 1'b0, 1'b0, 8'h00);
      chk("rxdata", q, b);
      chk("rxclr", rx_ready_o, 1'b0);
    end
    fork
      m.brk(30);
      begin
        repeat (25) @(posedge lclk);
        chk("break", sync_break_o, 1'b1);
      end
    join
    run = 1'b0;
    repeat (40) tick();
    // internal reset, then sync mode with 8 bits and no parity
    host(1'b1, 1'b1, 1'b1, 8'h40);
    host(1'b1, 1'b1, 1'b1, 8'h0C);
    host(1'b1, 1'b1, 1'b1, 8'h27);
    run = 1'b1;
    repeat (60) tick();
    b = 8'(rnd());
    // sync detect rises together with the first data bit
    fork
      m.send({2'h3, b});
      begin
        @(negedge lclk);
        tick();
        ext_sync_i = 1'b1;
      end
    join
    run = 1'b0;
    repeat (30) tick();
    host(1'b1, 1'b0, 1'b0, 8'h00);
    chk("sync_rx", q, b);
    rstn_i = 1'b0;
    #1;
    chk("rst_mid", outs, 8'hE6);
    tally_and_finish();
  end
endmodule : test_usart_ports
bind usart_ports usart_ports_chk chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .cnd_i(cnd_i),
  .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .cts_n_i(cts_n_i), .txc_n_i(txc_n_i), .oe_n_o(oe_n_o),
  .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o), .rx_ready_o(rx_ready_o), .txd_o(txd_o),
  .tx_empty_o(tx_empty_o), .tx_ready_o(tx_ready_o));
